// ==== logic/prox_pin_sync.sv ====
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/100ps
`default_nettype none
module prox_pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // Pins in, synchronised out
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            meta <= '0;
            o_sync <= '0;
        end
        else
        begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule
`default_nettype wire

// ==== logic/prox_scan_cfg.svh ====
// Timing and threshold constants for the proximity scan sequencer
`ifndef PROX_SCAN_CFG_SVH
`define PROX_SCAN_CFG_SVH
`define CORE_CLK_MHZ 250
// Sleep windows in ms, lower and upper bounds
`define NORMAL_SLEEP_MIN_MS 69
`define NORMAL_SLEEP_MAX_MS 105
`define LOWPWR_SLEEP_MIN_MS 572
`define LOWPWR_SLEEP_MAX_MS 845
// Mode pin reset pulse width held by the host, in us
`define MODE_PULSE_MIN_US 4500
// Cycles per ms at the core rate
`define CYCLES_PER_MS (`CORE_CLK_MHZ * 1000)
// Sleep actually used: the lower bound, times the cycles per ms
`define NORMAL_SLEEP_CYCLES (`NORMAL_SLEEP_MIN_MS * `CYCLES_PER_MS)
`define LOWPWR_SLEEP_CYCLES (`LOWPWR_SLEEP_MIN_MS * `CYCLES_PER_MS)
// Active scan length in cycles
`define SCAN_CYCLES 256
// Width of the cycle counter, and of the level and sensor values
`define COUNT_WIDTH 32
`define LEVEL_WIDTH 8
`endif

// ==== logic/prox_scan_pkg.sv ====
// Types shared by the proximity scan sequencer
package prox_scan_pkg;
    typedef enum logic [1:0] {st_scan, st_eval, st_sleep} seq_state_type;
endpackage

// ==== logic/proximity_scan_sequencer.sv ====
// Scan, sleep and detection sequencer of the proximity detector
`timescale 1ns/100ps
`default_nettype none
`include "prox_scan_cfg.svh"

module proximity_scan_sequencer
    import prox_scan_pkg::*;
#(
    parameter int unsigned NORMAL_SLEEP = `NORMAL_SLEEP_CYCLES,
    parameter int unsigned LOWPWR_SLEEP = `LOWPWR_SLEEP_CYCLES,
    parameter int unsigned SCAN_LEN = `SCAN_CYCLES,
    parameter int unsigned LW = `LEVEL_WIDTH
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // Pins from outside
    input wire logic i_power_mode_select_n,
    input wire logic [LW-1:0] i_sensitivity_level_input,
    // Digitised sensor reading from the front end, valid at end of scan
    input wire logic [LW-1:0] i_sensor_input,
    // Open-drain detect pin
    output logic o_detect_out_n,
    output logic o_detect_out_n_oe,
    // Status
    output logic o_scanning
);
    localparam int CW = `COUNT_WIDTH;

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    logic [2*LW:0] sync_out;
    logic mode_sync;
    logic [LW-1:0] level_sync;
    logic [LW-1:0] sensor_sync;

    prox_pin_sync #(.WIDTH(2*LW+1)) u_sync (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_async({i_power_mode_select_n, i_sensitivity_level_input, i_sensor_input}),
        .o_sync(sync_out)
    );
    assign mode_sync = sync_out[2*LW];
    assign level_sync = sync_out[2*LW-1:LW];
    assign sensor_sync = sync_out[LW-1:0];

    // ------------------------------------------------------------
    // Mode edge detection
    // ------------------------------------------------------------
    logic mode_prev;
    logic [2:0] prime_pipe;
    logic mode_primed;
    logic mode_edge;

    // Edges count only once the synchroniser and mode_prev hold real pin data,
    // so a high pin at reset release cannot fake an edge
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            mode_prev <= 1'b0;
            prime_pipe <= 3'h0;
        end
        else
        begin
            mode_prev <= mode_sync;
            prime_pipe <= {prime_pipe[1:0], 1'b1};
        end
    end
    assign mode_primed = prime_pipe[2];
    assign mode_edge = mode_primed && (mode_prev != mode_sync);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    seq_state_type state;
    logic [CW-1:0] count;
    logic detected;
    logic touched;
    logic [LW-1:0] threshold;
    logic [LW-1:0] baseline;
    logic hit;
    logic [CW-1:0] sleep_len;
    logic detected_next;
    logic touched_next;

    // Low level of the pin selects the long sleep
    assign sleep_len = mode_sync ? CW'(NORMAL_SLEEP) : CW'(LOWPWR_SLEEP);
    // Higher level raises the threshold, so supply is least sensitive
    assign hit = (sensor_sync > baseline) && ((sensor_sync - baseline) > threshold);

    // Scan, evaluate, then sleep unless a detection is held
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state <= st_scan;
            count <= '0;
        end
        else if (mode_edge)
        begin
            state <= st_scan;
            count <= '0;
        end
        else
        begin
            unique case (state)
                st_scan:
                begin
                    if (count >= CW'(SCAN_LEN - 1))
                    begin
                        state <= st_eval;
                        count <= '0;
                    end
                    else
                        count <= count + 1'b1;
                end
                st_eval:
                begin
                    // Next value of detected decides; hit covers the set case
                    if (detected_next)
                        state <= st_scan;
                    else
                        state <= st_sleep;
                    count <= '0;
                end
                st_sleep:
                begin
                    if (count >= sleep_len - 1'b1)
                    begin
                        state <= st_scan;
                        count <= '0;
                    end
                    else
                        count <= count + 1'b1;
                end
            endcase
        end
    end

    // Detection decision, taken only at the end of a scan
    // Touch test is one bit wider so a large threshold does not wrap when doubled
    always_comb
    begin
        detected_next = detected;
        touched_next = touched;
        if (detected && hit && ({1'b0, sensor_sync - baseline} > {threshold, 1'b0}))
            touched_next = 1'b1;
        else if (touched && !hit)
        begin
            detected_next = 1'b0;
            touched_next = 1'b0;
        end
        else if (hit)
            detected_next = 1'b1;
        else
            detected_next = 1'b0;
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            detected <= 1'b0;
            touched <= 1'b0;
        end
        else if (mode_edge)
        begin
            detected <= 1'b0;
            touched <= 1'b0;
        end
        else if (state == st_eval)
        begin
            detected <= detected_next;
            touched <= touched_next;
        end
    end

    // Threshold follows the level sampled after each scan
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            threshold <= '0;
        else if (state == st_eval)
            threshold <= level_sync;
    end

    // Baseline captured on each mode pin edge; the front end compensates drift
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            baseline <= '0;
        else if (mode_edge)
            baseline <= sensor_sync;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Pad data stays low; only the enable moves, so the pin never drives high
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_detect_out_n <= 1'b0;
            o_detect_out_n_oe <= 1'b0;
            o_scanning <= 1'b0;
        end
        else
        begin
            o_detect_out_n <= 1'b0;
            o_detect_out_n_oe <= detected;
            o_scanning <= (state == st_scan);
        end
    end
endmodule
`default_nettype wire

// ==== test/host_pullup.sv ====
// Host side of the open-drain detect line
`timescale 1ns/100ps
`default_nettype none
module host_pullup (
    // Pad from the sequencer
    input wire logic i_pad_data,
    input wire logic i_pad_oe,
    // Level seen by the host
    output logic o_line
);
    // Pull-up wins whenever the pad lets go
    assign o_line = i_pad_oe ? i_pad_data : 1'b1;
endmodule
`default_nettype wire

// ==== test/prox_scan_props.sv ====
// Port-level checks for the proximity scan sequencer
`timescale 1ns/100ps
`default_nettype none
module prox_scan_props #(
    parameter int unsigned NORMAL_SLEEP = 20,
    parameter int unsigned LOWPWR_SLEEP = 40,
    parameter int unsigned SCAN_LEN = 8,
    parameter int unsigned LW = 8
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // Watched pins
    input wire logic i_power_mode_select_n,
    input wire logic [LW-1:0] i_sensitivity_level_input,
    input wire logic [LW-1:0] i_sensor_input,
    input wire logic o_detect_out_n,
    input wire logic o_detect_out_n_oe,
    input wire logic o_scanning
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    logic [31:0] gap;
    logic [31:0] since;
    logic mode_q;
    // Idle length, and age of the last mode change so restarted gaps are skipped
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            gap <= 32'h0;
            since <= 32'h0;
            mode_q <= 1'b0;
        end
        else
        begin
            gap <= o_scanning ? 32'h0 : gap + 32'h1;
            since <= (i_power_mode_select_n != mode_q) ? 32'h0 : since + {31'h0, since != 32'hFFFFFFFF};
            mode_q <= i_power_mode_select_n;
        end
    end
    a_pad_data_low: assert property (o_detect_out_n == 1'b0)
        else $error("Detect pad data driven high");
    a_normal_sleep_len: assert property (
        $rose(o_scanning) && !o_detect_out_n_oe && i_power_mode_select_n && since > gap + 32'h4
        |-> gap >= NORMAL_SLEEP && gap <= NORMAL_SLEEP + 3) else $error("Normal sleep length wrong");
    a_lowpwr_sleep_len: assert property (
        $rose(o_scanning) && !o_detect_out_n_oe && !i_power_mode_select_n && since > gap + 32'h4
        |-> gap >= LOWPWR_SLEEP && gap <= LOWPWR_SLEEP + 3) else $error("Low-power sleep length wrong");
    a_detect_no_sleep: assert property ($fell(o_scanning) ##1 o_detect_out_n_oe |-> o_scanning)
        else $error("Sleep taken while detected");
    a_oe_after_scan: assert property ($rose(o_detect_out_n_oe) |-> $past(o_scanning, 2))
        else $error("Detect asserted without a finished scan");
    a_scan_full_len: assert property ($rose(o_scanning) |-> o_scanning [*8])
        else $error("Scan cut short");
    a_sleep_oe_steady: assert property (!o_scanning [*3] |-> $stable(o_detect_out_n_oe))
        else $error("Detect changed during sleep");
    a_mode_edge_release: assert property (
        $changed(i_power_mode_select_n) |-> ##5 !o_detect_out_n_oe [*6]) else $error("Mode edge kept detect");
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the proximity scan sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic mode_n = 1'b1;
    logic [7:0] level = 8'h10;
    logic [7:0] sensor = 8'h00;
    logic pad_data;
    logic pad_oe;
    logic scanning;
    logic line;
    int err_total = 0;
    int checked = 0;
    int cycles = 0;
    localparam int SLEEP_N = 20;
    localparam int SLEEP_LP = 40;
    // 250 MHz core clock, short sleeps keep the run small
    always #2 core_clk = ~core_clk;
    proximity_scan_sequencer #(.NORMAL_SLEEP(SLEEP_N), .LOWPWR_SLEEP(SLEEP_LP), .SCAN_LEN(8)) u_dut (
        .i_core_clk(core_clk), .i_arst_n(arst_n), .i_power_mode_select_n(mode_n),
        .i_sensitivity_level_input(level), .i_sensor_input(sensor),
        .o_detect_out_n(pad_data), .o_detect_out_n_oe(pad_oe), .o_scanning(scanning));
    host_pullup u_host (.i_pad_data(pad_data), .i_pad_oe(pad_oe), .o_line(line));
    task automatic final_report();
        $display("checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Drive all pins at a rising edge
    task automatic put(input logic m, input logic [7:0] lv, input logic [7:0] sn);
        @(posedge core_clk);
        mode_n <= m;
        level <= lv;
        sensor <= sn;
    endtask
    // Bounded wait for a line level, sampled at falling edges where it is settled
    task automatic wait_line(input logic lvl, input int lim);
        for (int i = 0; i < lim && line !== lvl; i++)
            @(negedge core_clk);
    endtask
    task automatic hold_line(input logic lvl, input int n);
        repeat (n)
        begin
            @(negedge core_clk);
            `CHK(line, lvl)
        end
    endtask
    // Low time of the scan flag: one evaluation cycle plus the sleep
    task automatic chk_gap(input int exp);
        int n;
        n = 0;
        while (scanning !== 1'b1)
            @(negedge core_clk);
        while (scanning !== 1'b0)
            @(negedge core_clk);
        while (scanning !== 1'b1 && n < 2000)
        begin
            n++;
            @(negedge core_clk);
        end
        `CHK(n, exp)
    endtask
    task automatic t_detect();
        put(1'b1, 8'h10, 8'h18);
        wait_line(1'b0, 80);
        `CHK(line, 1'b0)
        hold_line(1'b0, 60);
        put(1'b0, 8'h10, 8'h18);
        wait_line(1'b1, 12);
        `CHK(line, 1'b1)
        hold_line(1'b1, 30);
        put(1'b1, 8'h10, 8'h18);
        hold_line(1'b1, 80);
        $display("t_detect done");
    endtask
    task automatic t_sense();
        // A new level is judged from the scan after the one that samples it
        put(1'b1, 8'hFF, 8'h18);
        hold_line(1'b1, 40);
        put(1'b1, 8'hFF, 8'hFF);
        hold_line(1'b1, 100);
        put(1'b1, 8'h00, 8'hFF);
        wait_line(1'b0, 80);
        `CHK(line, 1'b0)
        hold_line(1'b0, 70);
        put(1'b1, 8'h00, 8'h18);
        wait_line(1'b1, 80);
        `CHK(line, 1'b1)
        hold_line(1'b1, 60);
        $display("t_sense done");
    endtask
    task automatic t_lowpwr();
        put(1'b0, 8'h00, 8'h18);
        hold_line(1'b1, 150);
        chk_gap(SLEEP_LP + 1);
        put(1'b0, 8'h00, 8'h40);
        wait_line(1'b0, 120);
        `CHK(line, 1'b0)
        hold_line(1'b0, 40);
        @(posedge core_clk);
        arst_n <= 1'b0;
        @(negedge core_clk);
        `CHK(line, 1'b1)
        @(posedge core_clk);
        arst_n <= 1'b1;
        wait_line(1'b0, 80);
        `CHK(line, 1'b0)
        put(1'b1, 8'h00, 8'h40);
        wait_line(1'b1, 12);
        `CHK(line, 1'b1)
        hold_line(1'b1, 100);
        chk_gap(SLEEP_N + 1);
        $display("t_lowpwr done");
    endtask
    // Hang guard well above the expected run
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            final_report();
        end
    end
    initial
    begin
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        hold_line(1'b1, 100);
        chk_gap(SLEEP_N + 1);
        $display("t_idle done");
        t_detect();
        t_sense();
        t_lowpwr();
        final_report();
    end
endmodule
bind proximity_scan_sequencer prox_scan_props #(.NORMAL_SLEEP(NORMAL_SLEEP), .LOWPWR_SLEEP(LOWPWR_SLEEP),
    .SCAN_LEN(SCAN_LEN), .LW(LW)) u_props (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
    .i_power_mode_select_n(i_power_mode_select_n), .i_sensitivity_level_input(i_sensitivity_level_input),
    .i_sensor_input(i_sensor_input), .o_detect_out_n(o_detect_out_n),
    .o_detect_out_n_oe(o_detect_out_n_oe), .o_scanning(o_scanning));
`default_nettype wire
